//--- rtl/sgc_pkg.sv
// How it works
// - eight-bit word into seven-bit shift register
// - enable high moves register into decode
// - code zero minimum, one step per code
// - codes 72 to 127 saturate at maximum
// - top bit ignored, upper half repeats
// - enable falling edge starts new load
// - msb first, one bit per rising edge
// - latched word held while enable low
// - enable rising edge applies shifted word
// - enable rising edge gates off shifting
// - power-down high selects forward amplifier
// - power-down low selects reverse amplifier
// - power-down falling edge disables output power
// - rising edge captures, falling edge to slave
// - power-down acts independent of serial clock
package sgc_pkg;
  localparam int          CODE_W     = 7;
  localparam logic [6:0]  CODE_MAX   = 7'h47;  // code 71, full gain
  localparam logic [6:0]  CODE_RST   = 7'h00;
  // gain in units of 0.1 mdB; step 0.7526 dB
  localparam int          STEP_UDB   = 7526;   // step in 0.1 mdB
  localparam int          MIN_UDB    = -274300; // -27.43 dB in 0.1 mdB
  localparam logic [1:0]  SYNC_RST   = 2'h0;
  typedef enum logic [1:0] {
    SGC_IDLE  = 2'h0,
    SGC_SHIFT = 2'h1
  } sgc_state_t;
  // saturating, top bit discarded by caller
  function automatic logic [6:0] sgc_decode(input logic [6:0] code);
    sgc_decode = (code > CODE_MAX) ? CODE_MAX : code;
  endfunction : sgc_decode
endpackage : sgc_pkg

//--- rtl/sgc_port.sv
`timescale 1ns/1ns
`default_nettype none
module sgc_port
  import sgc_pkg::*;
(
  input  wire logic       CLK,            // core clock, 25 MHz
  input  wire logic       SRST,           // sync reset, high
  input  wire logic       SCLK,           // serial clock pin
  input  wire logic       SERIAL_GAIN_IN, // serial data pin
  input  wire logic       LOAD_ENABLE_N,  // load enable, low active
  input  wire logic       AMP_SLEEP_N,    // power-down, low active
  output logic [6:0]      GAIN_CODE,      // latched raw code
  output logic [6:0]      GAIN_STEP,      // decoded gain step 0..71
  output logic            FWD_AMP_EN,     // forward amplifier on
  output logic            REV_AMP_EN,     // reverse amplifier on
  output logic            OUT_POWER_EN,   // output power on
  output logic            LOADING         // shift sequence active
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [3:0] pins_s;
  logic       sclk_s;
  logic       sdat_s;
  logic       len_s;
  logic       slp_s;
  sgc_sync #(.W(4)) u_sync (
    .clk  (CLK),
    .srst (SRST),
    .d    ({SCLK, SERIAL_GAIN_IN, LOAD_ENABLE_N, AMP_SLEEP_N}),
    .q    (pins_s)
  );
  assign sclk_s = pins_s[3];
  assign sdat_s = pins_s[2];
  assign len_s  = pins_s[1];
  assign slp_s  = pins_s[0];
  ////////////////////////////////////////////////////////////////////////////
  // edge history, taken from the synchronised copies only
  logic sclk_d;
  logic len_d;
  logic slp_d;
  logic next_sclk_d;
  logic next_len_d;
  logic next_slp_d;
  logic sclk_rise;
  logic sclk_fall;
  logic len_rise;
  logic len_fall;
  logic slp_fall;
  always_comb
  begin
    next_sclk_d = sclk_s;
    next_len_d  = len_s;
    next_slp_d  = slp_s;
    sclk_rise   = sclk_s & ~sclk_d;
    sclk_fall   = ~sclk_s & sclk_d;
    len_rise    = len_s & ~len_d;
    len_fall    = ~len_s & len_d;
    slp_fall    = ~slp_s & slp_d;
  end
  // history resets to the synchroniser's flush level (zero); a high reset
  // here would see a false enable fall and open a phantom load at release
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      sclk_d <= 1'b0;
      len_d  <= 1'b0;
      slp_d  <= 1'b0;
    end
    else
    begin
      sclk_d <= next_sclk_d;
      len_d  <= next_len_d;
      slp_d  <= next_slp_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // load sequence and master-slave shift register
  sgc_state_t      state;
  sgc_state_t      next_state;
  logic            master;
  logic            next_master;
  logic [6:0]      slave;
  logic [6:0]      next_slave;
  logic [6:0]      code;
  logic [6:0]      next_code;
  always_comb
  begin
    next_state  = state;
    next_master = master;
    next_slave  = slave;
    next_code   = code;
    case (state)
      SGC_IDLE:
      begin
        if (len_fall)
        begin
          next_state = SGC_SHIFT;
        end
      end
      SGC_SHIFT:
      begin
        // a rising edge falling in the same cycle as the enable rise is
        // dropped; the shift clock is gated from that instant on
        if (len_rise)
        begin
          next_state = SGC_IDLE;
          next_code  = slave;
        end
        else
        begin
          if (sclk_rise)
          begin
            next_master = sdat_s;
          end
          if (sclk_fall)
          begin
            // oldest bit falls off the top after seven more shifts
            next_slave = {slave[5:0], master};
          end
        end
      end
      default:
      begin
        next_state = SGC_IDLE;
      end
    endcase
  end
  // code only moves on the enable rise; power-down never touches it
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      state  <= SGC_IDLE;
      master <= 1'b0;
      slave  <= CODE_RST;
      code   <= CODE_RST;
    end
    else
    begin
      state  <= next_state;
      master <= next_master;
      slave  <= next_slave;
      code   <= next_code;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // gain decode and amplifier mode outputs
  logic [6:0] next_gain_code;
  logic [6:0] next_gain_step;
  logic       next_fwd;
  logic       next_rev;
  logic       next_pwr;
  logic       next_loading;
  always_comb
  begin
    next_gain_code = code;
    // seven stored bits mean the msb of the word never reaches here
    next_gain_step = sgc_decode(code);
    next_fwd       = slp_s;
    next_rev       = ~slp_s;
    next_pwr       = slp_s & ~slp_fall;
    next_loading   = (next_state == SGC_SHIFT);
  end
  // sleep is sampled by the core clock, not the serial clock; the pin is
  // otherwise independent of link activity at three cycles of latency
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      GAIN_CODE    <= CODE_RST;
      GAIN_STEP    <= CODE_RST;
      FWD_AMP_EN   <= 1'b0;
      REV_AMP_EN   <= 1'b1;
      OUT_POWER_EN <= 1'b0;
      LOADING      <= 1'b0;
    end
    else
    begin
      GAIN_CODE    <= next_gain_code;
      GAIN_STEP    <= next_gain_step;
      FWD_AMP_EN   <= next_fwd;
      REV_AMP_EN   <= next_rev;
      OUT_POWER_EN <= next_pwr;
      LOADING      <= next_loading;
    end
  end
endmodule : sgc_port
`default_nettype wire

//--- rtl/sgc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module sgc_sync
  import sgc_pkg::*;
#(
  parameter int W = 4
)(
  input  wire logic         clk,   // core clock
  input  wire logic         srst,  // sync reset
  input  wire logic [W-1:0] d,     // async pins
  output logic      [W-1:0] q      // synchronised
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;
  ////////////////////////////////////////////////////////////////////////////
  // two stages; meta is read only by the second stage
  always_comb
  begin
    next_meta = d;
    next_q    = meta;
  end
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= next_meta;
      q    <= next_q;
    end
  end
endmodule : sgc_sync
`default_nettype wire

//--- sim/sgc_host.sv
`timescale 1ns/1ns
`default_nettype none
module sgc_host (
  output logic sclk,  // serial clock, still between frames except for stray pulses
  output logic serial_gain_in, // gain bits
  output logic len_n  // load enable, low active
);
  // idle line levels
  initial
  begin
    sclk = 1'h0;
    serial_gain_in = 1'h0;
    len_n = 1'h1;
  end
  // one frame of n bits, msb first; odd n allowed
  task automatic send(input logic [15:0] w, input int n);
    #7 len_n = 1'h0;
    #200;
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_gain_in = w[i];
      #160 sclk = 1'h1;
      #160 sclk = 1'h0;
    end
    #160 len_n = 1'h1;
    serial_gain_in = ~serial_gain_in; // a released line must not look valid
    #400;
  endtask : send
  // clock pulses with the enable high, which must be ignored
  task automatic stray(input int n);
    serial_gain_in = 1'h1;
    repeat (n)
    begin
      #160 sclk = 1'h1;
      #160 sclk = 1'h0;
    end
  endtask : stray
endmodule : sgc_host
`default_nettype wire

//--- sim/sgc_port_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module sgc_port_monitor
  import sgc_pkg::*;
(
  input wire logic       CLK,           // clock
  input wire logic       SRST,          // reset
  input wire logic       LOAD_ENABLE_N, // enable pin
  input wire logic       AMP_SLEEP_N,   // sleep pin
  input wire logic [6:0] GAIN_CODE,     // code
  input wire logic [6:0] GAIN_STEP,     // step
  input wire logic       FWD_AMP_EN,    // fwd amp
  input wire logic       REV_AMP_EN,    // rev amp
  input wire logic       OUT_POWER_EN,  // power
  input wire logic       LOADING        // load open
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  // pins pass a two-stage synchroniser, so pin edges get a small window
  step_sat_a:
    assert property (GAIN_STEP == (GAIN_CODE > CODE_MAX ? CODE_MAX : GAIN_CODE))
      else $error("bad step");
  mode_excl_a:
    assert property (FWD_AMP_EN != REV_AMP_EN) else $error("bad mode");
  power_off_a:
    assert property (!FWD_AMP_EN |-> !OUT_POWER_EN) else $error("power on");
  sleep_fall_a:
    assert property ($fell(AMP_SLEEP_N) |-> ##[2:4] !FWD_AMP_EN && REV_AMP_EN)
      else $error("sleep late");
  code_hold_a:
    assert property (LOADING |-> $stable(GAIN_CODE)) else $error("code moved");
  code_cause_a:
    assert property ($changed(GAIN_CODE) |-> $past(LOADING, 2)
      && !$past(LOADING) && $past(LOAD_ENABLE_N, 3))
      else $error("stray code change");
  load_open_a:
    assert property ($fell(LOAD_ENABLE_N) |-> ##[2:4] LOADING)
      else $error("no load");
  load_close_a:
    assert property ($rose(LOAD_ENABLE_N) && LOADING |-> ##[3:5] !LOADING)
      else $error("load stuck");
endmodule : sgc_port_monitor
//////////
bind sgc_port sgc_port_monitor mon (.CLK(CLK), .SRST(SRST),
  .LOAD_ENABLE_N(LOAD_ENABLE_N), .AMP_SLEEP_N(AMP_SLEEP_N),
  .GAIN_CODE(GAIN_CODE), .GAIN_STEP(GAIN_STEP), .FWD_AMP_EN(FWD_AMP_EN),
  .REV_AMP_EN(REV_AMP_EN), .OUT_POWER_EN(OUT_POWER_EN), .LOADING(LOADING));
`default_nettype wire

//--- sim/sgc_port_test.sv
`timescale 1ns/1ns
`default_nettype none
module sgc_port_test;
  import sgc_pkg::*;
  logic        clk = 0, srst = 1, sleep_n = 1, was_ld = 0, was_ld2 = 0;
  logic        sclk, serial_gain_in, len_n, fwd, rev, pwr, ld;
  logic [6:0]  code, step, sr = 7'h00;
  logic [13:0] expq[$];
  logic [13:0] exp_v;
  logic [7:0]  words[9] = '{8'h00, 8'h01, 8'h46, 8'h47, 8'h48, 8'h7F,
                            8'h80, 8'hC7, 8'hFF};
  int          error_cnt = 0, checked = 0;
  integer      seed = 71;
  always #20 clk = ~clk;
  sgc_host host (.sclk(sclk), .serial_gain_in(serial_gain_in), .len_n(len_n));
  sgc_port DUT (.CLK(clk), .SRST(srst), .SCLK(sclk), .SERIAL_GAIN_IN(serial_gain_in),
    .LOAD_ENABLE_N(len_n), .AMP_SLEEP_N(sleep_n), .GAIN_CODE(code),
    .GAIN_STEP(step), .FWD_AMP_EN(fwd), .REV_AMP_EN(rev),
    .OUT_POWER_EN(pwr), .LOADING(ld));
  // verdict
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  // slave keeps the last seven bits shifted, across loads
  task automatic load(input logic [15:0] w, input int n);
    for (int i = n - 1; i >= 0; i--)
      sr = {sr[5:0], w[i]};
    expq.push_back({sr, sr > CODE_MAX ? CODE_MAX : sr});
    host.send(w, n);
  endtask : load
  // amplifier mode outputs against the expected levels
  task automatic chk_mode(input logic [2:0] e);
    checked++;
    if ({fwd, rev, pwr} !== e)
    begin
      error_cnt++;
      $display("[FAIL] %0t exp %h got %h", $time, e, {fwd, rev, pwr});
    end
  endtask : chk_mode
  // the code register settles one cycle after the busy flag falls
  always @(negedge clk)
  begin
    was_ld  <= ld;
    was_ld2 <= was_ld;
    if (was_ld2 === 1'h1 && was_ld === 1'h0)
    begin
      exp_v = expq.pop_front();
      checked++;
      if ({code, step} !== exp_v)
      begin
        error_cnt++;
        $display("[FAIL] %0t exp %h got %h", $time, exp_v, {code, step});
      end
    end
  end
  // main sequence
  initial
  begin
    repeat (6) @(negedge clk);
    srst = 1'h0;
    repeat (3) @(negedge clk);
    foreach (words[i]) load({8'h00, words[i]}, 8);
    repeat (6) load(16'($random(seed)), 8);
    load(16'h0005, 3);
    load(16'h3A5C, 10);
    host.stray(4);
    load(16'h0002, 3);
    @(negedge clk);
    sleep_n = 1'h0;
    repeat (4) @(negedge clk);
    chk_mode(3'h2);
    load(16'h0033, 8);
    @(negedge clk);
    sleep_n = 1'h1;
    repeat (4) @(negedge clk);
    chk_mode(3'h5);
    repeat (6) @(negedge clk);
    tally_and_finish;
  end
  // watchdog
  initial
  begin
    #300000;
    error_cnt++;
    tally_and_finish;
  end
endmodule : sgc_port_test
`default_nettype wire
